// [hdl/datapath_and_pin_config_regs.sv]
// apb register bank for auxiliary pin pair, datapath control and strap readback
`default_nettype none

module datapath_and_pin_config_regs
    import dp_pin_pkg::*;
#(
    parameter int STRAP_SETTLE = dp_pin_pkg::STRAP_SETTLE_CYC
)
(
    input  wire logic                                sys_clk,
    input  wire logic                                reset,
    // apb slave
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [dp_pin_pkg::APB_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                         pwdata,
    input  wire logic [3:0]                          pstrb,
    output logic [31:0]                              prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    // auxiliary pins
    input  wire logic                                aux_pin_seven_in,
    output logic                                     aux_pin_seven_out,
    output logic                                     aux_pin_seven_oe_n,
    output logic                                     aux_pin_seven_func_in,
    input  wire logic                                aux_pin_eight_in,
    output logic                                     aux_pin_eight_out,
    output logic                                     aux_pin_eight_oe_n,
    output logic                                     aux_pin_eight_func_in,
    // strap pins, already resolved to a three-bit level code
    input  wire logic [dp_pin_pkg::STRAP_CODE_W-1:0] strap_select_upper,
    input  wire logic [dp_pin_pkg::STRAP_CODE_W-1:0] strap_select_lower,
    // video and audio datapath
    input  wire logic                                pixel_valid_strobe,
    input  wire logic                                repeater_mode,
    input  wire logic                                inband_audio_valid,
    input  wire logic                                inband_second_channel,
    output logic                                     pixel_forward,
    output logic                                     pixel_valid_active_low,
    output logic                                     packet_audio_block,
    output logic                                     audio_regen_select,
    output logic                                     video_18bit_mode,
    output logic                                     audio_frame_transport,
    output logic                                     second_audio_enable
);

    // ========================================================================
    // state
    typedef struct packed {
        logic [7:0]      pin_pair;
        logic [7:0]      datapath;
        logic [31:0]     rdata;
        logic            err;
        logic [1:0][2:0] pin_sync;
        logic [1:0]      pin_level;
        logic [1:0]      pin_out;
        logic [1:0]      pin_oe_n;
        logic [1:0]      pin_func;
        logic [6:0]      dp_out;
    } bank_state_t;

    bank_state_t st_reg;
    bank_state_t st_next;

    logic [1:0]              pin_raw;
    logic [1:0][1:0]         pin_mode;
    logic [1:0]              pin_value;
    logic [1:0]              strap_done;
    logic [1:0][2:0]         strap_code;
    logic [1:0][2:0]         strap_raw;
    logic [7:0]              strap_view;
    logic                    setup;
    logic                    access;
    reg_sel_t                wsel;

    // ========================================================================
    // helper functions
    function automatic reg_sel_t decode_addr(input logic [APB_ADDR_W-1:0] a);
        reg_sel_t s;
        s = SEL_NONE;
        unique case (a)
            ADDR_PIN_PAIR:   s = SEL_PIN_PAIR;
            ADDR_DATAPATH:   s = SEL_DATAPATH;
            ADDR_STRAP:      s = SEL_STRAP;
            ADDR_PIN_STATUS: s = SEL_STATUS;
            default:         s = SEL_NONE;
        endcase
        return s;
    endfunction

    // returns {oe_n, out, func_route}
    function automatic logic [2:0] pin_drive(input logic [1:0] mode, input logic value);
        logic [2:0] d;
        d = 3'b100;
        unique case (pin_mode_t'(mode))
            PIN_FUNC_IN: d = 3'b101;
            PIN_GP_OUT:  d = {1'b0, value, 1'b0};
            PIN_HIZ:     d = 3'b100;
            PIN_GP_IN:   d = 3'b100;
        endcase
        return d;
    endfunction

    // pass mode forwards every pixel, otherwise the strobe is judged by its polarity
    function automatic logic forward_pixel(input logic pass, input logic active_low, input logic strobe);
        logic f;
        f = 1'b0;
        if (pass)
        begin
            f = 1'b1;
        end
        else
        begin
            f = strobe ^ active_low;
        end
        return f;
    endfunction

    // ========================================================================
    // strap capture
    // each latch synchronises its own copy of an asynchronous level code
    assign strap_raw[0] = strap_select_lower;
    assign strap_raw[1] = strap_select_upper;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_strap
            strap_level_latch #(
                .CODE_W        (STRAP_CODE_W),
                .SETTLE_CYCLES (STRAP_SETTLE)
            ) u_latch (
                .sys_clk  (sys_clk),
                .reset    (reset),
                .level_in (strap_raw[g]),
                .done     (strap_done[g]),
                .code     (strap_code[g])
            );
        end
    endgenerate

    always_comb
    begin
        strap_view                                         = 8'h00;
        strap_view[STRAP_UP_DONE_BIT]                      = strap_done[1];
        strap_view[STRAP_UP_LSB +: STRAP_CODE_W]           = strap_code[1];
        strap_view[STRAP_LO_DONE_BIT]                      = strap_done[0];
        strap_view[STRAP_LO_LSB +: STRAP_CODE_W]           = strap_code[0];
    end

    // ========================================================================
    // pin field views
    assign pin_raw[0]   = aux_pin_seven_in;
    assign pin_raw[1]   = aux_pin_eight_in;
    assign pin_mode[0]  = st_reg.pin_pair[PIN7_MODE_LSB +: 2];
    assign pin_mode[1]  = st_reg.pin_pair[PIN8_MODE_LSB +: 2];
    // value bits only reach a pin that is in output mode
    assign pin_value[0] = st_reg.pin_pair[PIN7_VALUE_BIT];
    assign pin_value[1] = st_reg.pin_pair[PIN8_VALUE_BIT];

    // ========================================================================
    // apb handshake
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign wsel   = decode_addr(paddr);

    // ========================================================================
    // next state
    always_comb
    begin
        logic [2:0] drv;
        logic       chb;
        drv     = 3'b000;
        chb     = 1'b0;
        st_next = st_reg;

        // input synchronisers, level moves once stages two and three agree
        for (int i = 0; i < 2; i++)
        begin
            st_next.pin_sync[i] = {st_reg.pin_sync[i][1:0], pin_raw[i]};
            if (st_reg.pin_sync[i][1] == st_reg.pin_sync[i][2])
            begin
                st_next.pin_level[i] = st_reg.pin_sync[i][2];
            end
            drv                  = pin_drive(pin_mode[i], pin_value[i]);
            st_next.pin_oe_n[i]  = drv[2];
            st_next.pin_out[i]   = drv[1];
            st_next.pin_func[i]  = drv[0] & st_reg.pin_level[i];
        end

        // register read, prepared in the setup phase
        // so the data stands from a flip-flop through the zero-wait access phase
        if (setup)
        begin
            st_next.rdata = 32'h0000_0000;
            st_next.err   = 1'b0;
            unique case (wsel)
                SEL_PIN_PAIR: st_next.rdata[7:0] = st_reg.pin_pair;
                SEL_DATAPATH: st_next.rdata[7:0] = st_reg.datapath;
                SEL_STRAP:    st_next.rdata[7:0] = strap_view;
                SEL_STATUS:   st_next.rdata[1:0] = st_reg.pin_level;
                SEL_NONE:     st_next.err        = 1'b1;
                default:      st_next.err        = 1'b1;
            endcase
        end

        // register write, only the low byte lane carries data
        // reserved bits are masked off, read-only targets keep their contents
        if (access && pwrite && pstrb[0])
        begin
            unique case (wsel)
                SEL_PIN_PAIR: st_next.pin_pair = pwdata[7:0] & PIN_PAIR_WMASK;
                SEL_DATAPATH: st_next.datapath = pwdata[7:0] & DATAPATH_WMASK;
                SEL_STRAP:    st_next.err      = st_reg.err;
                SEL_STATUS:   st_next.err      = st_reg.err;
                SEL_NONE:     st_next.err      = st_reg.err;
                default:      st_next.err      = st_reg.err;
            endcase
        end

        // datapath controls
        st_next.dp_out[0] = forward_pixel(st_reg.datapath[DP_PASS_RGB_BIT], st_reg.datapath[DP_PV_POL_BIT],
                                          pixel_valid_strobe);
        st_next.dp_out[1] = st_reg.datapath[DP_PV_POL_BIT];
        st_next.dp_out[2] = st_reg.datapath[DP_PASS_RGB_BIT];
        st_next.dp_out[3] = st_reg.datapath[DP_AUDIO_REGEN_BIT];
        st_next.dp_out[4] = st_reg.datapath[DP_VIDEO18_BIT];
        st_next.dp_out[5] = st_reg.datapath[DP_AUDIO_FRAME_BIT];
        if (st_reg.datapath[DP_CHB_OVR_BIT])
        begin
            chb = st_reg.datapath[DP_CHB_EN_BIT];
        end
        else if (repeater_mode && inband_audio_valid)
        begin
            chb = inband_second_channel;
        end
        else
        begin
            chb = st_reg.datapath[DP_CHB_EN_BIT];
        end
        st_next.dp_out[6] = chb;
    end

    // ========================================================================
    // registers
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            st_reg          <= '0;
            st_reg.pin_pair <= PIN_PAIR_RST;
            st_reg.datapath <= DATAPATH_RST;
            // pins stay undriven while reset is held
            st_reg.pin_oe_n <= 2'b11;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ========================================================================
    // outputs
    assign prdata  = st_reg.rdata;
    // zero wait states: every access phase completes at once
    assign pready  = access;
    assign pslverr = access & st_reg.err;

    assign aux_pin_seven_out     = st_reg.pin_out[0];
    assign aux_pin_seven_oe_n    = st_reg.pin_oe_n[0];
    assign aux_pin_seven_func_in = st_reg.pin_func[0];
    assign aux_pin_eight_out     = st_reg.pin_out[1];
    assign aux_pin_eight_oe_n    = st_reg.pin_oe_n[1];
    assign aux_pin_eight_func_in = st_reg.pin_func[1];

    assign pixel_forward          = st_reg.dp_out[0];
    assign pixel_valid_active_low = st_reg.dp_out[1];
    assign packet_audio_block     = st_reg.dp_out[2];
    assign audio_regen_select     = st_reg.dp_out[3];
    assign video_18bit_mode       = st_reg.dp_out[4];
    assign audio_frame_transport  = st_reg.dp_out[5];
    assign second_audio_enable    = st_reg.dp_out[6];

endmodule // datapath_and_pin_config_regs

`default_nettype wire

// [hdl/dp_pin_pkg.sv]
// shared constants and types of the datapath and auxiliary pin register bank
`default_nettype none

package dp_pin_pkg;

    // ========================================================================
    // clock and timing
    localparam int CLK_FREQ_MHZ       = 100;
    localparam int STRAP_SETTLE_NS    = 2000;
    localparam int STRAP_SETTLE_CYC   = (STRAP_SETTLE_NS * CLK_FREQ_MHZ + 999) / 1000;

    // ========================================================================
    // register indices and byte addresses
    localparam int             APB_ADDR_W     = 12;
    localparam logic [7:0]     IDX_PIN_PAIR   = 8'h11;
    localparam logic [7:0]     IDX_DATAPATH   = 8'h12;
    localparam logic [7:0]     IDX_STRAP      = 8'h13;
    localparam logic [7:0]     IDX_PIN_STATUS = 8'h20;
    localparam logic [11:0]    ADDR_PIN_PAIR   = {2'b00, IDX_PIN_PAIR, 2'b00};
    localparam logic [11:0]    ADDR_DATAPATH   = {2'b00, IDX_DATAPATH, 2'b00};
    localparam logic [11:0]    ADDR_STRAP      = {2'b00, IDX_STRAP, 2'b00};
    localparam logic [11:0]    ADDR_PIN_STATUS = {2'b00, IDX_PIN_STATUS, 2'b00};

    // ========================================================================
    // field positions
    localparam int PIN8_VALUE_BIT     = 7;
    localparam int PIN8_MODE_LSB      = 4;
    localparam int PIN7_VALUE_BIT     = 3;
    localparam int PIN7_MODE_LSB      = 0;
    localparam int DP_PASS_RGB_BIT    = 6;
    localparam int DP_PV_POL_BIT      = 5;
    localparam int DP_AUDIO_REGEN_BIT = 4;
    localparam int DP_CHB_OVR_BIT     = 3;
    localparam int DP_VIDEO18_BIT     = 2;
    localparam int DP_AUDIO_FRAME_BIT = 1;
    localparam int DP_CHB_EN_BIT      = 0;
    localparam int STRAP_UP_DONE_BIT  = 7;
    localparam int STRAP_UP_LSB       = 4;
    localparam int STRAP_LO_DONE_BIT  = 3;
    localparam int STRAP_LO_LSB       = 0;
    localparam int STRAP_CODE_W       = 3;

    // ========================================================================
    // reset values and write masks
    localparam logic [7:0]              PIN_PAIR_RST   = 8'h00;
    localparam logic [7:0]              DATAPATH_RST   = 8'h00;
    localparam logic [7:0]              STRAP_RST      = 8'h88;
    localparam logic                    STRAP_DONE_RST = 1'b1;
    localparam logic [STRAP_CODE_W-1:0] STRAP_CODE_RST = 3'h0;
    localparam logic [7:0]              PIN_PAIR_WMASK = 8'hbb;
    localparam logic [7:0]              DATAPATH_WMASK = 8'h7f;

    // ========================================================================
    // enumerations
    typedef enum logic [1:0] {
        PIN_FUNC_IN = 2'b00,
        PIN_GP_OUT  = 2'b01,
        PIN_HIZ     = 2'b10,
        PIN_GP_IN   = 2'b11
    } pin_mode_t;

    typedef enum logic [2:0] {
        SEL_NONE     = 3'b000,
        SEL_PIN_PAIR = 3'b001,
        SEL_DATAPATH = 3'b010,
        SEL_STRAP    = 3'b011,
        SEL_STATUS   = 3'b100
    } reg_sel_t;

    typedef enum logic [1:0] {
        STRAP_ARM    = 2'b00,
        STRAP_SETTLE = 2'b01,
        STRAP_HELD   = 2'b10
    } strap_state_t;

endpackage : dp_pin_pkg

`default_nettype wire

// [hdl/strap_level_latch.sv]
// synchroniser and settle-then-latch capture of one multi-level strap code
`default_nettype none

module strap_level_latch
    import dp_pin_pkg::*;
#(
    parameter int CODE_W        = dp_pin_pkg::STRAP_CODE_W,
    parameter int SETTLE_CYCLES = dp_pin_pkg::STRAP_SETTLE_CYC
)
(
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic [CODE_W-1:0] level_in,
    output logic                   done,
    output logic [CODE_W-1:0]      code
);

    localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYCLES - 1);

    typedef struct packed {
        logic [2:0][CODE_W-1:0] sync;
        logic [CODE_W-1:0]      cand;
        logic [CNT_W-1:0]       cnt;
        strap_state_t           state;
        logic                   done;
        logic [CODE_W-1:0]      code;
    } latch_state_t;

    latch_state_t st_reg;
    latch_state_t st_next;

    // ========================================================================
    // settle and latch
    always_comb
    begin
        st_next         = st_reg;
        st_next.sync[0] = level_in;
        st_next.sync[1] = st_reg.sync[0];
        st_next.sync[2] = st_reg.sync[1];
        unique case (st_reg.state)
            STRAP_ARM:
            begin
                st_next.done  = 1'b0;
                st_next.cnt   = '0;
                st_next.cand  = st_reg.sync[1];
                st_next.state = STRAP_SETTLE;
            end
            STRAP_SETTLE:
            begin
                if (st_reg.sync[1] != st_reg.sync[2] || st_reg.sync[1] != st_reg.cand)
                begin
                    st_next.cand = st_reg.sync[1];
                    st_next.cnt  = '0;
                end
                else if (st_reg.cnt == CNT_LAST)
                begin
                    st_next.code  = st_reg.cand;
                    st_next.done  = 1'b1;
                    st_next.state = STRAP_HELD;
                end
                else
                begin
                    st_next.cnt = st_reg.cnt + CNT_W'(1);
                end
            end
            STRAP_HELD:
            begin
                st_next.state = STRAP_HELD;
            end
            default:
            begin
                st_next.state = STRAP_ARM;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            st_reg       <= '0;
            st_reg.state <= STRAP_ARM;
            st_reg.done  <= STRAP_DONE_RST;
            st_reg.code  <= STRAP_CODE_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign done = st_reg.done;
    assign code = st_reg.code;

endmodule // strap_level_latch

`default_nettype wire

// [sim/dp_regs_asserts.sv]
// concurrent checks on the ports of the datapath and pin register bank
`default_nettype none

module dp_regs_asserts
    import dp_pin_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        aux_pin_seven_out,
    input wire logic        aux_pin_seven_oe_n,
    input wire logic        aux_pin_seven_func_in,
    input wire logic        aux_pin_eight_out,
    input wire logic        aux_pin_eight_oe_n,
    input wire logic        pixel_valid_strobe,
    input wire logic        pixel_forward,
    input wire logic        pixel_valid_active_low,
    input wire logic        packet_audio_block,
    input wire logic        audio_regen_select,
    input wire logic        video_18bit_mode,
    input wire logic        audio_frame_transport,
    input wire logic        second_audio_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================================
    // access decode
    logic acc;
    logic wr_pp;
    logic wr_dp;
    logic mapped;
    assign acc    = psel && penable;
    assign wr_pp  = acc && pwrite && pstrb[0] && (paddr == ADDR_PIN_PAIR);
    assign wr_dp  = acc && pwrite && pstrb[0] && (paddr == ADDR_DATAPATH);
    assign mapped = (paddr == ADDR_PIN_PAIR) || (paddr == ADDR_DATAPATH) || (paddr == ADDR_STRAP)
                    || (paddr == ADDR_PIN_STATUS);

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    // ========================================================================
    // properties
    AST_PREADY: assert property (acc |-> pready) else $error("ready missing in access");
    AST_PIN7: assert property (wr_pp |-> ##2 (aux_pin_seven_oe_n == ($past(pwdata[1:0], 2) != 2'b01))
        && (aux_pin_seven_oe_n || aux_pin_seven_out == $past(pwdata[3], 2))) else $error("pin seven drive");
    AST_PIN8: assert property (wr_pp |-> ##2 (aux_pin_eight_oe_n == ($past(pwdata[5:4], 2) != 2'b01))
        && (aux_pin_eight_oe_n || aux_pin_eight_out == $past(pwdata[7], 2))) else $error("pin eight drive");
    AST_FUNC: assert property (!aux_pin_seven_oe_n |-> !aux_pin_seven_func_in) else $error("func input while driven");
    AST_DPOUT: assert property (wr_dp |-> ##2 {pixel_valid_active_low, audio_regen_select, video_18bit_mode,
        audio_frame_transport} == {$past(pwdata[5:4], 2), $past(pwdata[2:1], 2)}) else $error("datapath outputs");
    AST_PASS: assert property (wr_dp |-> ##2 packet_audio_block == $past(pwdata[6], 2)) else $error("pass rgb");
    AST_CHB: assert property (wr_dp && pwdata[3] |-> ##2 second_audio_enable == $past(pwdata[0], 2))
        else $error("channel b override");
    AST_FWD: assert property (pixel_forward == (packet_audio_block
        || ($past(pixel_valid_strobe) != pixel_valid_active_low))) else $error("pixel forward");
    AST_ERR: assert property (acc |-> pslverr == !mapped) else $error("slave error decode");
    AST_RSV: assert property (acc && !pwrite && !pslverr |-> prdata[31:8] == 24'h0
        && (paddr != ADDR_PIN_PAIR || (!prdata[6] && !prdata[2])) && (paddr != ADDR_DATAPATH || !prdata[7]))
        else $error("reserved bits read nonzero");
endmodule // dp_regs_asserts

bind datapath_and_pin_config_regs dp_regs_asserts u_dp_regs_asserts (
    .sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .aux_pin_seven_out, .aux_pin_seven_oe_n, .aux_pin_seven_func_in, .aux_pin_eight_out, .aux_pin_eight_oe_n,
    .pixel_valid_strobe, .pixel_forward, .pixel_valid_active_low, .packet_audio_block, .audio_regen_select,
    .video_18bit_mode, .audio_frame_transport, .second_audio_enable
);

`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench of the datapath and pin register bank
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dp_pin_pkg::*;

    logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic pready, pslverr, er, o7, e7, f7, o8, e8, f8, fwd, pol, blk, rgn, v18, afr, chb;
    logic in7 = 1'b1, in8 = 1'b0, strobe = 1'b0, rep = 1'b0, ibv = 1'b0, ib2 = 1'b0;
    logic [2:0] s_up = 3'h5, s_lo = 3'h2;
    int errors = 0;
    int comparisons = 0;

    always #5 sys_clk = ~sys_clk;

    datapath_and_pin_config_regs #(.STRAP_SETTLE(4)) u_datapath_and_pin_config_regs (
        .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .aux_pin_seven_in(in7), .aux_pin_seven_out(o7), .aux_pin_seven_oe_n(e7), .aux_pin_seven_func_in(f7),
        .aux_pin_eight_in(in8), .aux_pin_eight_out(o8), .aux_pin_eight_oe_n(e8), .aux_pin_eight_func_in(f8),
        .strap_select_upper(s_up), .strap_select_lower(s_lo), .pixel_valid_strobe(strobe),
        .repeater_mode(rep), .inband_audio_valid(ibv), .inband_second_channel(ib2), .pixel_forward(fwd),
        .pixel_valid_active_low(pol), .packet_audio_block(blk), .audio_regen_select(rgn),
        .video_18bit_mode(v18), .audio_frame_transport(afr), .second_audio_enable(chb)
    );

    // ========================================================================
    // helpers
    task report_and_stop;
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one apb transfer, held until ready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            errors++;
            report_and_stop();
        end
        else
        begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // ========================================================================
    // scenarios
    task t_reset_values;
        apb(1'b0, ADDR_PIN_PAIR, 32'h0);
        chk("pin_pair_rst", rd, 32'h0);
        apb(1'b0, ADDR_DATAPATH, 32'h0);
        chk("datapath_rst", rd, 32'h0);
        apb(1'b0, ADDR_PIN_STATUS, 32'h0);
        chk("pin_status", rd, 32'h1);
    endtask

    task t_pin_modes;
        logic [1:0] m;
        in8 <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            m = i[1:0];
            apb(1'b1, ADDR_PIN_PAIR, {24'h0, 1'b1, 1'b0, m, 1'b1, 1'b0, m});
            cyc(8);
            chk("oe7", e7, m != 2'b01);
            chk("oe8", e8, m != 2'b01);
            chk("func7", f7, m == 2'b00);
            chk("func8", f8, m == 2'b00);
            if (m == 2'b01)
            begin
                chk("out7", o7, 1'b1);
                chk("out8", o8, 1'b1);
            end
        end
        apb(1'b1, ADDR_PIN_PAIR, 32'h11);
        cyc(2);
        chk("out7_low", o7, 1'b0);
        chk("out8_low", o8, 1'b0);
        apb(1'b1, ADDR_PIN_PAIR, 32'hff);
        apb(1'b0, ADDR_PIN_PAIR, 32'h0);
        chk("pin_pair_mask", rd, 32'hbb);
        apb(1'b0, ADDR_PIN_STATUS, 32'h0);
        chk("pin_status_both", rd, 32'h3);
    endtask

    task t_datapath;
        apb(1'b1, ADDR_DATAPATH, 32'hff);
        apb(1'b0, ADDR_DATAPATH, 32'h0);
        chk("dp_mask", rd, 32'h7f);
        cyc(1);
        chk("dp_all", {fwd, blk, pol, rgn, v18, afr, chb}, 7'h7f);
        apb(1'b1, ADDR_DATAPATH, 32'h20);
        @(posedge sys_clk);
        strobe <= 1'b1;
        cyc(2);
        chk("fwd_low_active", {fwd, v18, afr, rgn}, 4'h0);
        @(posedge sys_clk);
        strobe <= 1'b0;
        rep <= 1'b1;
        ibv <= 1'b1;
        ib2 <= 1'b1;
        cyc(2);
        chk("fwd_idle", fwd, 1'b1);
        apb(1'b1, ADDR_DATAPATH, 32'h00);
        cyc(2);
        chk("chb_inband", chb, 1'b1);
        apb(1'b1, ADDR_DATAPATH, 32'h08);
        cyc(2);
        chk("chb_override", chb, 1'b0);
        @(posedge sys_clk);
        rep <= 1'b0;
        apb(1'b1, ADDR_DATAPATH, 32'h15);
        cyc(2);
        chk("dp_mixed", {rgn, v18, afr, chb, fwd, blk}, 6'b110100);
    endtask

    task t_strap_and_map;
        apb(1'b0, ADDR_STRAP, 32'h0);
        chk("strap_up", rd[7:4], 4'hd);
        chk("strap_lo", rd[31:0] & 32'hffff_ff0f, 32'h0000_000a);
        apb(1'b1, ADDR_STRAP, 32'h0);
        apb(1'b0, ADDR_STRAP, 32'h0);
        chk("strap_ro", rd, 32'hda);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("unmapped_err", er, 1'b1);
        apb(1'b1, 12'h040, 32'hff);
        chk("unmapped_wr", er, 1'b1);
    endtask

    // ========================================================================
    // main sequence and watchdog
    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset_values();
        t_pin_modes();
        t_datapath();
        t_strap_and_map();
        report_and_stop();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        report_and_stop();
    end
endmodule // tb_top

`default_nettype wire
